// >>> urc_pkg.sv
package urc_pkg;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLOCK_HZ        = 200_000_000;
  localparam int BIT_RATE_BPS    = 115_200;
  localparam int BIT_CYCLES_DEF  = CLOCK_HZ / BIT_RATE_BPS;
  localparam int IR_PULSE_NUM    = 3;
  localparam int IR_PULSE_DEN    = 16;

  // ****************************************************************
  // Register port addresses.
  // ****************************************************************
  localparam logic [1:0] ADDR_DATA  = 2'h0;
  localparam logic [1:0] ADDR_LEVEL = 2'h1;
  localparam logic [1:0] ADDR_EXTRA = 2'h2;

  // ****************************************************************
  // Extra features control field positions and reset value.
  // ****************************************************************
  localparam int EXTRA_MULTIDROP = 0;
  localparam int EXTRA_RX_OFF    = 1;
  localparam int EXTRA_TX_OFF    = 2;
  localparam int EXTRA_TX_DIR    = 4;
  localparam int EXTRA_DIR_INV   = 5;
  localparam int EXTRA_IR_MODE   = 7;
  localparam logic [7:0] EXTRA_WRITABLE = 8'hB7;
  localparam logic [7:0] EXTRA_RESET    = 8'h00;

  // ****************************************************************
  // FIFO sizing and frame layout.
  // ****************************************************************
  localparam int FIFO_DEPTH   = 64;
  localparam int FIFO_AW      = 6;
  localparam int LEVEL_W      = 7;
  localparam int CHAR_BITS    = 8;
  localparam int MARK_BITS    = 9;
  localparam logic [3:0] FRAME_BITS_NORMAL = 4'hA;
  localparam logic [3:0] FRAME_BITS_MARKED = 4'hB;

  typedef enum logic [1:0] {
    URC_RX_IDLE  = 2'b00,
    URC_RX_START = 2'b01,
    URC_RX_DATA  = 2'b11,
    URC_RX_STOP  = 2'b10
  } urc_rx_state_t;

endpackage

// >>> urc_tx_shifter.sv
`timescale 1ns/1ps
module urc_tx_shifter #(
  parameter int BIT_CYCLES = urc_pkg::BIT_CYCLES_DEF
) (
  input  wire logic                      CLOCK,
  input  wire logic                      RESETN,
  input  wire logic                      start,
  input  wire logic [urc_pkg::MARK_BITS-1:0] data,
  input  wire logic                      nine_bit,
  input  wire logic                      ir_enable,
  output logic                           txd,
  output logic                           ir_out,
  output logic                           busy
);
  import urc_pkg::*;

  localparam int CW           = $clog2(BIT_CYCLES + 1);
  localparam int PULSE_CYCLES = (IR_PULSE_NUM * BIT_CYCLES + IR_PULSE_DEN - 1) / IR_PULSE_DEN;

  logic [10:0]   shreg;
  logic [3:0]    bits_left;
  logic [CW-1:0] cnt;
  logic          next_ir;
  wire           bit_end = (cnt == CW'(BIT_CYCLES - 1));

  // The SIR encoder pulses for three sixteenths of each zero bit.
  assign next_ir = ir_enable && busy && !shreg[0] && (cnt < CW'(PULSE_CYCLES));

  // ****************************************************************
  // Shifter: loads a whole frame and sends it LSB first.
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      shreg     <= 11'h7FF;
      bits_left <= 4'h0;
      cnt       <= '0;
      busy      <= 1'b0;
    end else if (start && !busy) begin
      shreg     <= nine_bit ? {1'b1, data, 1'b0} : {2'h3, data[CHAR_BITS-1:0], 1'b0};
      bits_left <= nine_bit ? FRAME_BITS_MARKED : FRAME_BITS_NORMAL;
      cnt       <= '0;
      busy      <= 1'b1;
    end else if (busy) begin
      cnt <= bit_end ? '0 : cnt + CW'(1);
      if (bit_end) begin
        shreg     <= {1'b1, shreg[10:1]};
        bits_left <= bits_left - 4'h1;
        busy      <= (bits_left != 4'h1);
      end
    end
  end

  // Registered line outputs; the line idles high.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      txd    <= 1'b1;
      ir_out <= 1'b0;
    end else begin
      txd    <= busy ? shreg[0] : 1'b1;
      ir_out <= next_ir;
    end
  end

  a_ir_zero_only: assert property (@(posedge CLOCK) disable iff (!RESETN)
    ir_out |-> !txd) else $error("Infrared pulse seen on a one bit.");
  a_frame_start_bit: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $rose(busy) |=> !txd) else $error("Frame did not open with a start bit.");
endmodule

// >>> urc_uart_core.sv
`timescale 1ns/1ps
module urc_uart_core #(
  parameter int BIT_CYCLES = urc_pkg::BIT_CYCLES_DEF
) (
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  input  wire logic       HOST_WRITE,
  input  wire logic       HOST_READ,
  input  wire logic [1:0] HOST_ADDR,
  input  wire logic [7:0] HOST_WDATA,
  input  wire logic       HOST_WMARK,
  output logic      [7:0] HOST_RDATA,
  output logic            HOST_RMARK,
  input  wire logic       RX,
  output logic            TX,
  output logic            IR_TX,
  input  wire logic       MODEM_RTS_BIT,
  input  wire logic       FLOW_RTS_ENABLE,
  input  wire logic       FLOW_RTS_LEVEL,
  output logic            RTS_N,
  output logic            MULTIDROP_MODE
);
  import urc_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES + 1);

  // Next FIFO fill count from push and pop strobes.
  function automatic logic [LEVEL_W-1:0] fifo_count(input logic [LEVEL_W-1:0] c, input logic push,
                                                    input logic pop);
    fifo_count = c + LEVEL_W'(push) - LEVEL_W'(pop);
  endfunction

  // ****************************************************************
  // Register port decode.
  // ****************************************************************
  logic [7:0]         extra_features_control;
  logic [MARK_BITS-1:0] tx_mem [FIFO_DEPTH];
  logic [MARK_BITS-1:0] rx_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [LEVEL_W-1:0] tx_count, receive_fifo_fill_level;
  logic               rx_push;
  logic [MARK_BITS-1:0] rx_push_data;
  logic               tx_start, shifter_busy, tx_pending;
  logic               next_pending, next_rts;

  wire transmitter_off   = extra_features_control[EXTRA_TX_OFF];
  wire receiver_off      = extra_features_control[EXTRA_RX_OFF];
  wire multidrop         = extra_features_control[EXTRA_MULTIDROP];
  wire transmitter_drives_direction = extra_features_control[EXTRA_TX_DIR];
  wire direction_polarity_invert    = extra_features_control[EXTRA_DIR_INV];
  wire ir_mode           = extra_features_control[EXTRA_IR_MODE];
  wire tx_full  = (tx_count == LEVEL_W'(FIFO_DEPTH));
  wire tx_empty = (tx_count == '0);
  wire rx_full  = (receive_fifo_fill_level == LEVEL_W'(FIFO_DEPTH));
  wire rx_empty = (receive_fifo_fill_level == '0);
  wire tx_write = HOST_WRITE && (HOST_ADDR == ADDR_DATA) && !tx_full;
  wire rx_pop   = HOST_READ && (HOST_ADDR == ADDR_DATA) && !rx_empty;
  wire rx_store = rx_push && !rx_full;

  // Extra features register; reserved bits are masked off on write.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      extra_features_control <= EXTRA_RESET;
    end else if (HOST_WRITE && (HOST_ADDR == ADDR_EXTRA)) begin
      extra_features_control <= HOST_WDATA & EXTRA_WRITABLE;
    end
  end

  // Read data is registered; the level register has bit 7 tied low.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      HOST_RDATA <= 8'h00;
      HOST_RMARK <= 1'b0;
    end else if (HOST_READ) begin
      unique case (HOST_ADDR)
        ADDR_DATA:  HOST_RDATA <= rx_empty ? 8'h00 : rx_mem[rx_rp][CHAR_BITS-1:0];
        ADDR_LEVEL: HOST_RDATA <= {1'b0, receive_fifo_fill_level};
        ADDR_EXTRA: HOST_RDATA <= extra_features_control;
        default:    HOST_RDATA <= 8'h00;
      endcase
      HOST_RMARK <= (HOST_ADDR == ADDR_DATA) && !rx_empty && rx_mem[rx_rp][CHAR_BITS];
    end
  end

  // ****************************************************************
  // Transmit and receive FIFOs.
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (tx_write) begin
      tx_mem[tx_wp] <= {HOST_WMARK, HOST_WDATA};
    end
    if (rx_store) begin
      rx_mem[rx_wp] <= rx_push_data;
    end
  end

  // Pointers and counts; a drop on a full receive FIFO loses the character.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      tx_count <= '0;
      receive_fifo_fill_level <= '0;
    end else begin
      tx_wp <= tx_wp + FIFO_AW'(tx_write);
      tx_rp <= tx_rp + FIFO_AW'(tx_start);
      rx_wp <= rx_wp + FIFO_AW'(rx_store);
      rx_rp <= rx_rp + FIFO_AW'(rx_pop);
      tx_count <= fifo_count(tx_count, tx_write, tx_start);
      receive_fifo_fill_level <= fifo_count(receive_fifo_fill_level, rx_store, rx_pop);
    end
  end

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  // No new character is started while the transmitter is off.
  assign tx_start = !transmitter_off && !tx_empty && !shifter_busy;

  urc_tx_shifter #(.BIT_CYCLES(BIT_CYCLES)) u_shift_register (
    .CLOCK     (CLOCK),
    .RESETN    (RESETN),
    .start     (tx_start),
    .data      (tx_mem[tx_rp]),
    .nine_bit  (multidrop),
    .ir_enable (!ir_mode),
    .txd       (TX),
    .ir_out    (IR_TX),
    .busy      (shifter_busy)
  );

  // Pending data: set by a write, cleared after the last bit has left.
  assign next_pending = tx_write || (tx_pending && !(tx_empty && !shifter_busy));

  // Direction pin source; transmitter control wins over the other two.
  assign next_rts = transmitter_drives_direction ? (!next_pending ^ direction_polarity_invert)
                  : FLOW_RTS_ENABLE ? FLOW_RTS_LEVEL : !MODEM_RTS_BIT;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      tx_pending     <= 1'b0;
      RTS_N          <= 1'b1;
      MULTIDROP_MODE <= 1'b0;
    end else begin
      tx_pending     <= next_pending;
      RTS_N          <= next_rts;
      MULTIDROP_MODE <= multidrop;
    end
  end

  // ****************************************************************
  // Receiver.
  // ****************************************************************
  logic          rx_meta, rx_line;
  urc_rx_state_t rx_state;
  logic [CW-1:0] rx_cnt;
  logic [3:0]    rx_bits;
  logic [MARK_BITS-1:0] rx_shreg;
  wire  [3:0]    rx_data_bits = multidrop ? 4'(MARK_BITS) : 4'(CHAR_BITS);
  wire           rx_half      = (rx_cnt == CW'(BIT_CYCLES / 2 - 1));
  wire           rx_full_bit  = (rx_cnt == CW'(BIT_CYCLES - 1));
  wire           rx_abort     = receiver_off && (rx_state != URC_RX_IDLE);

  // Two-stage synchroniser on the receive pin.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rx_meta <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      rx_meta <= RX;
      rx_line <= rx_meta;
    end
  end

  // Completed characters are pushed aligned to bit 0; cut-short ones are pushed with their bits left at the top.
  assign rx_push      = rx_abort || ((rx_state == URC_RX_STOP) && rx_full_bit);
  assign rx_push_data = multidrop ? rx_shreg : {1'b0, rx_shreg[MARK_BITS-1:1]};

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rx_state <= URC_RX_IDLE;
      rx_cnt   <= '0;
      rx_bits  <= 4'h0;
      rx_shreg <= '0;
    end else if (rx_abort) begin
      rx_state <= URC_RX_IDLE;
    end else begin
      rx_cnt <= (rx_state == URC_RX_IDLE) || rx_full_bit || ((rx_state == URC_RX_START) && rx_half)
                ? '0 : rx_cnt + CW'(1);
      unique case (rx_state)
        URC_RX_IDLE: begin
          rx_bits  <= 4'h0;
          rx_shreg <= '0;
          if (!receiver_off && !rx_line) rx_state <= URC_RX_START;
        end
        URC_RX_START: if (rx_half) rx_state <= rx_line ? URC_RX_IDLE : URC_RX_DATA;
        URC_RX_DATA: if (rx_full_bit) begin
          rx_shreg <= {rx_line, rx_shreg[MARK_BITS-1:1]};
          rx_bits  <= rx_bits + 4'h1;
          if (rx_bits == rx_data_bits - 4'h1) rx_state <= URC_RX_STOP;
        end
        URC_RX_STOP: if (rx_full_bit) rx_state <= URC_RX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence s_host_fill;
    tx_write && transmitter_drives_direction && !direction_polarity_invert;
  endsequence
  sequence s_drained;
    transmitter_drives_direction && !direction_polarity_invert && tx_pending && !next_pending;
  endsequence

  a_level_bound: assert property (@(posedge CLOCK) disable iff (!RESETN)
    receive_fifo_fill_level <= LEVEL_W'(FIFO_DEPTH)) else $error("Receive level above depth.");
  a_level_top_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
    HOST_READ && HOST_ADDR == ADDR_LEVEL |=> HOST_RDATA[7] == 1'b0) else $error("Level bit 7 set.");
  a_rts_drop_write: assert property (@(posedge CLOCK) disable iff (!RESETN)
    s_host_fill |=> RTS_N == 1'b0) else $error("Direction pin did not drop on write.");
  a_rts_rise_drain: assert property (@(posedge CLOCK) disable iff (!RESETN)
    s_drained |=> RTS_N && !shifter_busy) else $error("Direction pin wrong after drain.");
  a_rts_invert: assert property (@(posedge CLOCK) disable iff (!RESETN)
    transmitter_drives_direction && direction_polarity_invert && next_pending |=> RTS_N)
    else $error("Inverted direction level wrong.");
  a_rts_manual: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !transmitter_drives_direction && !FLOW_RTS_ENABLE |=> RTS_N == !$past(MODEM_RTS_BIT))
    else $error("Direction pin not following modem control.");
  a_tx_off_quiet: assert property (@(posedge CLOCK) disable iff (!RESETN)
    transmitter_off && !shifter_busy |=> !$rose(shifter_busy)) else $error("Character started while off.");
  a_tx_fill_off: assert property (@(posedge CLOCK) disable iff (!RESETN)
    transmitter_off && tx_write |=> tx_count == $past(tx_count) + LEVEL_W'(1))
    else $error("Write refused while transmitter off.");
  a_rx_stop_now: assert property (@(posedge CLOCK) disable iff (!RESETN)
    rx_abort |-> rx_push ##1 rx_state == URC_RX_IDLE) else $error("Receiver did not stop at once.");
  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !extra_features_control[6] && !extra_features_control[3]) else $error("Reserved bit set.");
endmodule

// >>> urc_line_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Line transceiver model: drives the receive line, decodes frames.
// ****************************************************************
module urc_line_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       CLOCK,
  input  wire logic       TX,
  output logic            RX,
  output logic      [7:0] rx_byte,
  output int              rx_count
);
  logic [7:0] shift;

  // The line idles high through its bias network.
  initial begin
    RX       = 1'b1;
    rx_byte  = 8'h00;
    rx_count = 0;
  end

  // Sends the first n bits of start, data LSB first, stop; then idles high.
  task automatic send(input logic [7:0] b, input int n);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < n; i++) begin
      @(posedge CLOCK);
      #1 RX = frame[i];
      repeat (BIT_CYCLES - 1) @(posedge CLOCK);
    end
    @(posedge CLOCK);
    #1 RX = 1'b1;
  endtask

  // Samples each transmitted frame in the middle of its bits.
  always begin
    @(negedge TX);
    repeat (BIT_CYCLES / 2) @(posedge CLOCK);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYCLES) @(posedge CLOCK);
      if (i < 8) shift[i] = TX;
    end
    rx_byte = shift;
    rx_count++;
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Testbench for the receive level and extra features block.
// ****************************************************************
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  import urc_pkg::*;
  localparam int BC = 16;
  typedef struct {logic [7:0] w; logic md, fe, fl; logic [7:0] rb; logic rts, mm;} urc_row_t;
  logic       CLOCK = 0, RESETN = 0, HOST_WRITE = 0, HOST_READ = 0, HOST_WMARK = 0;
  logic       MODEM_RTS_BIT = 0, FLOW_RTS_ENABLE = 0, FLOW_RTS_LEVEL = 0;
  logic [1:0] HOST_ADDR = 2'h0;
  logic [7:0] HOST_WDATA = 8'h00, HOST_RDATA, d, rx_byte;
  logic       HOST_RMARK, RX, TX, IR_TX, RTS_N, MULTIDROP_MODE, on;
  int         fail_count = 0, samples_checked = 0, cycles = 0, run = 0, run_max = 0, n, k, prev_k;
  urc_row_t   rows [7] = '{
    '{8'h00, 1, 0, 0, 8'h00, 0, 0}, '{8'h00, 0, 0, 0, 8'h00, 1, 0},  // Modem bit drives the pin.
    '{8'h00, 1, 1, 1, 8'h00, 1, 0}, '{8'h00, 0, 1, 0, 8'h00, 0, 0},  // Flow control drives the pin.
    '{8'hFF, 0, 0, 0, 8'hB7, 0, 1}, '{8'h49, 0, 0, 0, 8'h01, 1, 1},  // Reserved bits, inversion.
    '{8'h10, 1, 0, 0, 8'h10, 1, 0}};                                  // Transmitter overrides modem.

  urc_uart_core #(.BIT_CYCLES(BC)) i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .HOST_WRITE(HOST_WRITE),
    .HOST_READ(HOST_READ), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA), .HOST_WMARK(HOST_WMARK),
    .HOST_RDATA(HOST_RDATA), .HOST_RMARK(HOST_RMARK), .RX(RX), .TX(TX), .IR_TX(IR_TX),
    .MODEM_RTS_BIT(MODEM_RTS_BIT), .FLOW_RTS_ENABLE(FLOW_RTS_ENABLE), .FLOW_RTS_LEVEL(FLOW_RTS_LEVEL),
    .RTS_N(RTS_N), .MULTIDROP_MODE(MULTIDROP_MODE));
  urc_line_model #(.BIT_CYCLES(BC)) i_line (.CLOCK(CLOCK), .TX(TX), .RX(RX), .rx_byte(rx_byte),
    .rx_count(k));

  // Clock generation, 5 ns period.
  always #2.5 CLOCK = ~CLOCK;

  // Tracks the longest infrared pulse and cuts a hung run short.
  always @(posedge CLOCK) begin
    run = IR_TX ? run + 1 : 0;
    if (run > run_max) run_max = run;
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  // Waits c edges and lands just after the last one.
  task automatic tick(input int c);
    repeat (c) @(posedge CLOCK);
    #1;
  endtask

  // One-cycle write strobe on the register port, then one idle edge so that
  // back-to-back writes never raise the strobe in the step that lowers it.
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    HOST_ADDR = a;
    HOST_WDATA = v;
    HOST_WRITE = 1'b1;
    tick(1);
    HOST_WRITE = 1'b0;
    tick(1);
  endtask

  // One-cycle read strobe; the data is taken once it has settled.
  task automatic rd(input logic [1:0] a);
    HOST_ADDR = a;
    HOST_READ = 1'b1;
    tick(1);
    HOST_READ = 1'b0;
    tick(1);
    d = HOST_RDATA;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    tick(3);
    RESETN = 1'b1;
    `CHK("reset rts", 1'b1, RTS_N)
    rd(ADDR_EXTRA); `CHK("reset extra", 8'h00, d)
    rd(ADDR_LEVEL); `CHK("reset level", 8'h00, d)
    // Register table: write, read back and watch the pin and the mode.
    foreach (rows[i]) begin
      MODEM_RTS_BIT = rows[i].md;
      FLOW_RTS_ENABLE = rows[i].fe;
      FLOW_RTS_LEVEL = rows[i].fl;
      wr(ADDR_EXTRA, rows[i].w);
      rd(ADDR_EXTRA); `CHK("extra rb", rows[i].rb, d)
      `CHK("pin level", rows[i].rts, RTS_N)
      `CHK("multidrop", rows[i].mm, MULTIDROP_MODE)
    end
    FLOW_RTS_ENABLE = 1'b0;
    wr(ADDR_EXTRA, 8'h00);
    // Fill the receive side past full, then drain it in order.
    for (int i = 0; i < 65; i++) i_line.send(8'(i), 10);
    tick(4);
    rd(ADDR_LEVEL); `CHK("full level", 8'h40, d)
    for (int i = 0; i < 64; i++) begin
      rd(ADDR_DATA); `CHK("rx data", 8'(i), d)
    end
    rd(ADDR_LEVEL); `CHK("empty level", 8'h00, d)
    // Receiver turned off in mid-character keeps the partial bits.
    i_line.send(8'h0F, 5);
    wr(ADDR_EXTRA, 8'h02);
    tick(3);
    rd(ADDR_LEVEL); `CHK("cut level", 8'h01, d)
    i_line.send(8'h33, 10);
    rd(ADDR_LEVEL); `CHK("off level", 8'h01, d)
    rd(ADDR_DATA); `CHK("cut data", 8'hF0, d)
    // Nine-bit mode: the stop bit of a plain frame lands as the mark bit.
    wr(ADDR_EXTRA, 8'h01);
    i_line.send(8'hA6, 10);
    tick(BC);
    rd(ADDR_DATA); `CHK("mark data", 8'hA6, d)
    `CHK("mark bit", 1'b1, HOST_RMARK)
    // Direction control in both polarities, with the infrared pulse width.
    for (int inv = 0; inv < 2; inv++) begin
      wr(ADDR_EXTRA, inv ? 8'h30 : 8'h10);
      prev_k = k;
      run_max = 0;
      wr(ADDR_DATA, inv ? 8'hC3 : 8'h3C);
      tick(1);
      on = (inv != 0);
      `CHK("pin on", on, RTS_N)
      for (n = 0; n < 300 && RTS_N === on; n++) tick(1);
      `CHK("pin hold", 1'b1, n >= 10 * BC - 2 && n <= 10 * BC + 6)
      `CHK("frame", inv ? 8'hC3 : 8'h3C, rx_byte)
      `CHK("frame count", prev_k + 1, k)
      `CHK("ir pulse", (3 * BC + 15) / 16, run_max)
    end
    // Transmitter off: the current frame finishes, a queued one waits.
    wr(ADDR_EXTRA, 8'h00);
    wr(ADDR_DATA, 8'h55);
    tick(4 * BC);
    wr(ADDR_EXTRA, 8'h04);
    tick(8 * BC);
    `CHK("finish", 8'h55, rx_byte)
    wr(ADDR_DATA, 8'h66);
    n = 0;
    repeat (12 * BC) begin
      tick(1);
      if (TX !== 1'b1) n++;
    end
    `CHK("tx quiet", 0, n)
    wr(ADDR_EXTRA, 8'h00);
    tick(12 * BC);
    `CHK("queued", 8'h66, rx_byte)
    print_verdict();
  end
endmodule
